//--- rbs_pkg.sv
package rbs_pkg;

  // lock latency after the external reset is released, in input clock cycles
  localparam int unsigned LOCK_CYCLES      = 4096;
  localparam int unsigned LOCK_CNT_W       = 13;
  // least low time of the external reset after power-up, in input clock periods
  localparam int unsigned MIN_RESET_PERIODS = 4;
  // settling time of the clock multiplier at power-up
  localparam int unsigned PLL_SETTLE_US    = 100;
  localparam int unsigned CLK_PERIOD_PS    = 50000;
  localparam int unsigned PLL_SETTLE_CYCLES = (PLL_SETTLE_US * 1000000) / CLK_PERIOD_PS;

  localparam logic [31:0] RESET_VECTOR     = 32'h0009_0000;
  localparam logic [1:0]  BOOT_CFG_RESET   = 2'h0;
  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYCLES - 1);
  localparam logic [LOCK_CNT_W-1:0] CNT_ZERO  = '0;

  typedef enum logic [1:0] {
    RBS_IN_RESET = 2'b00,
    RBS_LOCKING  = 2'b01,
    RBS_RUNNING  = 2'b10
  } rbs_state_type;

  // strobe pin group of the parallel port: values and active-low enables
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic addr_latch;
  } rbs_strobe_type;

  // core start request
  typedef struct packed {
    logic        start;
    logic [31:0] vector;
  } rbs_core_start_type;

endpackage

//--- rbs_sync.sv
`timescale 1ns/1ps
module rbs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

//--- rbs_reset_boot_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - core reset state is driven out on a dedicated reset mirror pin
// - after reset release, wait 4096 input clocks for lock before core release
// - after the lock wait, core starts fetching at the fixed reset vector
// - low test reset clears test state machine; board pulses it after power-up
// - read, write, address latch strobes float only while reset is active
module rbs_reset_boot_sequencer (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        reset_in_n,
  input  wire logic [1:0]                  boot_config_select,
  input  wire logic                        test_reset_n,
  input  wire logic                        rd_n_core,
  input  wire logic                        wr_n_core,
  input  wire logic                        addr_latch_core,
  output logic                             core_reset,
  output logic                             core_reset_mirror_out,
  output rbs_pkg::rbs_core_start_type      core_start,
  output logic [1:0]                       boot_mode,
  output logic                             test_logic_reset,
  output rbs_pkg::rbs_strobe_type          strobe_out,
  output rbs_pkg::rbs_strobe_type          strobe_oe_n,
  output logic                             emulation_status_out,
  output logic                             emulation_status_oe_n
);

  logic                              reset_sync_n;
  logic [1:0]                        boot_sync;
  logic                              test_reset_sync_n;
  rbs_pkg::rbs_state_type            state;
  rbs_pkg::rbs_state_type            next_state;
  logic [rbs_pkg::LOCK_CNT_W-1:0]    lock_cnt;
  logic [rbs_pkg::LOCK_CNT_W-1:0]    next_lock_cnt;
  logic                              reset_active;
  logic                              lock_done;
  logic                              start_pulse;
  rbs_pkg::rbs_strobe_type           strobe_val;

  // all pins cross two flops before use
  rbs_sync #(
    .WIDTH (4)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({reset_in_n, boot_config_select, test_reset_n}),
    .sync_out ({reset_sync_n, boot_sync, test_reset_sync_n})
  );

  assign reset_active = ~reset_sync_n;
  assign lock_done    = (lock_cnt == rbs_pkg::LOCK_LAST);
  assign start_pulse  = (state == rbs_pkg::RBS_LOCKING) && lock_done && reset_sync_n;

  always_comb begin
    next_state    = state;
    next_lock_cnt = lock_cnt;
    case (state)
      rbs_pkg::RBS_IN_RESET: begin
        next_lock_cnt = rbs_pkg::CNT_ZERO;
        if (reset_sync_n) begin
          next_state = rbs_pkg::RBS_LOCKING;
        end
      end
      rbs_pkg::RBS_LOCKING: begin
        if (!reset_sync_n) begin
          next_state    = rbs_pkg::RBS_IN_RESET;
          next_lock_cnt = rbs_pkg::CNT_ZERO;
        end else if (lock_done) begin
          next_state = rbs_pkg::RBS_RUNNING;
        end else begin
          next_lock_cnt = lock_cnt + 1'b1;
        end
      end
      rbs_pkg::RBS_RUNNING: begin
        if (!reset_sync_n) begin
          next_state    = rbs_pkg::RBS_IN_RESET;
          next_lock_cnt = rbs_pkg::CNT_ZERO;
        end
      end
      default: begin
        next_state    = rbs_pkg::RBS_IN_RESET;
        next_lock_cnt = rbs_pkg::CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state    <= rbs_pkg::RBS_IN_RESET;
      lock_cnt <= rbs_pkg::CNT_ZERO;
    end else begin
      state    <= next_state;
      lock_cnt <= next_lock_cnt;
    end
  end

  // boot mode caught while reset is low; board keeps pins stable then
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      boot_mode <= rbs_pkg::BOOT_CFG_RESET;
    end else if (reset_active) begin
      boot_mode <= boot_sync;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_reset            <= 1'b1;
      core_reset_mirror_out <= 1'b0;
      core_start            <= '0;
      test_logic_reset      <= 1'b1;
    end else begin
      core_reset            <= (next_state != rbs_pkg::RBS_RUNNING);
      core_reset_mirror_out <= ~(next_state != rbs_pkg::RBS_RUNNING);
      core_start.start      <= start_pulse;
      core_start.vector     <= rbs_pkg::RESET_VECTOR;
      test_logic_reset      <= ~test_reset_sync_n;
    end
  end

  // strobes idle high after reset; pads float whole time reset is seen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strobe_val <= '1;
    end else begin
      strobe_val.rd_n       <= rd_n_core;
      strobe_val.wr_n       <= wr_n_core;
      strobe_val.addr_latch <= addr_latch_core;
    end
  end

  assign strobe_out  = strobe_val;
  assign strobe_oe_n = {3{reset_active | rst}};

  // open drain status pin: never pulled low by this block, pull-up holds it
  assign emulation_status_out  = 1'b0;
  assign emulation_status_oe_n = 1'b1;

  // entry into the lock wait, then the core held through its first cycles
  sequence s_lock_entry;
    (state == rbs_pkg::RBS_IN_RESET) ##1 (state == rbs_pkg::RBS_LOCKING);
  endsequence

  sequence s_core_held;
    core_reset [*8];
  endsequence

  property p_lock_wait;
    @(posedge ref_clk) disable iff (rst)
      s_lock_entry |-> s_core_held;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("core released early");

  // counter advances by one each locking cycle before the last count while reset stays released
  property p_count_step;
    @(posedge ref_clk) disable iff (rst)
      (state == rbs_pkg::RBS_LOCKING && reset_sync_n && !lock_done) |=> (lock_cnt == $past(lock_cnt) + 1'b1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("lock count did not advance");

  // core leaves reset only from the last count value, never earlier
  property p_release_count;
    @(posedge ref_clk) disable iff (rst)
      $fell(core_reset) |-> ($past(state) == rbs_pkg::RBS_LOCKING && $past(lock_cnt) == rbs_pkg::LOCK_LAST);
  endproperty
  a_release_count: assert property (p_release_count) else $error("core released before full count");

  property p_release_on_count;
    @(posedge ref_clk) disable iff (rst)
      start_pulse |=> (!core_reset && core_start.start);
  endproperty
  a_release_on_count: assert property (p_release_on_count) else $error("core not released");

  property p_count_restart;
    @(posedge ref_clk) disable iff (rst)
      (state == rbs_pkg::RBS_LOCKING && !reset_sync_n) |=> (lock_cnt == rbs_pkg::CNT_ZERO && core_reset);
  endproperty
  a_count_restart: assert property (p_count_restart) else $error("lock count not restarted");

  property p_vector;
    @(posedge ref_clk) disable iff (rst)
      core_start.start |-> (core_start.vector == rbs_pkg::RESET_VECTOR && $past(state) == rbs_pkg::RBS_LOCKING);
  endproperty
  a_vector: assert property (p_vector) else $error("start at wrong vector");

  property p_mirror;
    @(posedge ref_clk) disable iff (rst)
      core_reset_mirror_out == (state == rbs_pkg::RBS_RUNNING);
  endproperty
  a_mirror: assert property (p_mirror) else $error("reset mirror differs from core");

  property p_strobe_float;
    @(posedge ref_clk) disable iff (rst)
      reset_active |-> (strobe_oe_n == 3'h7);
  endproperty
  a_strobe_float: assert property (p_strobe_float) else $error("strobes driven in reset");

  property p_strobe_drive;
    @(posedge ref_clk) disable iff (rst)
      !reset_active |-> (strobe_oe_n == 3'h0);
  endproperty
  a_strobe_drive: assert property (p_strobe_drive) else $error("strobes not driven");

  property p_test_reset;
    @(posedge ref_clk) disable iff (rst)
      !test_reset_sync_n |=> test_logic_reset;
  endproperty
  a_test_reset: assert property (p_test_reset) else $error("test logic not reset");

  // boot pins may move freely once released; captured mode must not follow
  property p_boot_hold;
    @(posedge ref_clk) disable iff (rst)
      !reset_active |=> $stable(boot_mode);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot mode moved outside reset");

endmodule

//--- rbs_board.sv
`timescale 1ns/1ps
module rbs_board (
  input  wire logic  ref_clk,
  output logic       reset_in_n,
  output logic [1:0] boot_config_select,
  output logic       test_reset_n,
  output logic       test_clock
);
  // both resets low from power-up until the bench lets go
  initial begin
    reset_in_n = 1'b0;
    boot_config_select = 2'h0;
    test_reset_n = 1'b0;
    test_clock = 1'b0;
  end
  // test clock kept low all run; simplest way to satisfy the power-up need
  task automatic pulse(input logic [1:0] cfg, input int n);
    @(posedge ref_clk);
    #5 boot_config_select = cfg;
    @(posedge ref_clk);
    #5 reset_in_n = 1'b0;
    repeat (n) @(posedge ref_clk);
    #5 reset_in_n = 1'b1;
  endtask
  task automatic set_test(input logic v);
    @(posedge ref_clk);
    #5 test_reset_n = v;
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [1:0] cfg; logic [2:0] stb;} rbs_row_type;
  logic                        ref_clk = 1'b0;
  logic                        rst = 1'b1;
  logic                        reset_in_n;
  logic                        test_reset_n;
  logic [1:0]                  boot_config_select;
  logic [1:0]                  boot_mode;
  logic [2:0]                  core_strobe;
  logic                        core_reset;
  logic                        core_reset_mirror_out;
  logic                        test_logic_reset;
  logic                        emulation_status_out;
  logic                        emulation_status_oe_n;
  rbs_pkg::rbs_core_start_type core_start;
  rbs_pkg::rbs_strobe_type     strobe_out;
  rbs_pkg::rbs_strobe_type     strobe_oe_n;
  int                          n_errors = 0;
  int                          checks = 0;
  rbs_row_type rows[4] = '{'{2'h0, 3'h7}, '{2'h1, 3'h2}, '{2'h2, 3'h5}, '{2'h3, 3'h0}};

  always #25 ref_clk = ~ref_clk;

  rbs_board i_board (
    .ref_clk(ref_clk), .reset_in_n(reset_in_n),
    .boot_config_select(boot_config_select), .test_reset_n(test_reset_n), .test_clock());

  rbs_reset_boot_sequencer i_dut (
    .ref_clk(ref_clk), .rst(rst), .reset_in_n(reset_in_n),
    .boot_config_select(boot_config_select), .test_reset_n(test_reset_n),
    .rd_n_core(core_strobe[2]), .wr_n_core(core_strobe[1]), .addr_latch_core(core_strobe[0]),
    .core_reset(core_reset), .core_reset_mirror_out(core_reset_mirror_out),
    .core_start(core_start), .boot_mode(boot_mode), .test_logic_reset(test_logic_reset),
    .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n),
    .emulation_status_out(emulation_status_out), .emulation_status_oe_n(emulation_status_oe_n));

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one reset pulse, then time the release of the core
  task automatic run_lock(input logic [1:0] cfg);
    int cyc;
    cyc = 0;
    i_board.pulse(cfg, 4);
    chk("oe_in_reset", strobe_oe_n, 3'h7);
    chk("mirror_low", core_reset_mirror_out, 1'b0);
    while (core_reset !== 1'b0 && cyc < 5000) begin
      @(posedge ref_clk);
      #5 cyc++;
    end
    if (cyc >= 5000) begin
      n_errors++;
      give_verdict();
    end
    // synchroniser lag widens the window by a few cycles
    chk("lock_cycles", cyc >= rbs_pkg::LOCK_CYCLES && cyc <= rbs_pkg::LOCK_CYCLES + 5, 1'b1);
    chk("start", core_start, {1'b1, rbs_pkg::RESET_VECTOR});
    chk("mirror_high", core_reset_mirror_out, 1'b1);
    chk("boot_mode", boot_mode, cfg);
    @(posedge ref_clk);
    #5 chk("start_pulse", core_start.start, 1'b0);
  endtask

  initial begin
    core_strobe = 3'h7;
    repeat (20) @(posedge ref_clk);
    #5 rst = 1'b0;
    chk("core_reset", core_reset, 1'b1);
    chk("test_logic_reset", test_logic_reset, 1'b1);
    i_board.set_test(1'b1);
    repeat (3) @(posedge ref_clk);
    #5 chk("test_logic_reset", test_logic_reset, 1'b0);
    for (int i = 0; i < 4; i++) begin
      core_strobe = rows[i].stb;
      run_lock(rows[i].cfg);
      chk("strobe_out", strobe_out, rows[i].stb);
      chk("oe_running", strobe_oe_n, 3'h0);
    end
    // reset again mid-count: the wait must start over
    i_board.pulse(2'h1, 4);
    repeat (2000) @(posedge ref_clk);
    run_lock(2'h2);
    i_board.set_test(1'b0);
    repeat (3) @(posedge ref_clk);
    #5 chk("test_logic_reset", test_logic_reset, 1'b1);
    chk("emu_out", emulation_status_out, 1'b0);
    chk("emu_oe_n", emulation_status_oe_n, 1'b1);
    give_verdict();
  end
endmodule
